// ===== rtl/nva_arbiter.sv
`include "nva_params.svh"

// Summary of operation
// RL1 - smallest default priority number is the most urgent
// RL2 - simultaneous maskable requests are picked by fixed default order
// RL3 - serial ports map to priorities 19-21, 41-43 with their codes
// RL4 - interval timer matches use priorities 22, 23, codes 01E0H, 01F0H
// RL5 - timers 2 to 5 use priorities 31-34, 36-39, codes 0270H-02F0H
// RL6 - auto serial, converter, key, watch sources use 24, 26-29
// RL7 - baud match 30, second auto serial 35, clocked serial 40
// RL8 - two-wire sources 25 and 44 exist only when fitted
// RL9 - handler address equals exception code zero-extended to 32 bits
// RL10 - acceptance saves return address into the matching save register
// RL11 - abandoned load, divide or frame instruction saves its own address
// RL12 - software subtracts four from saved address for a bad opcode
// RL13 - non-maskable requests ignore disable state and beat maskable ones
// RL14 - three non-maskable sources: pin, watchdog one, watchdog two
// RL15 - pin edge selectable as rising, falling, both or none
// RL16 - watchdog one raises a request only when its mode bits are 10
// RL17 - watchdog two raises a request only when its mode bits are 01
// RL18 - coincident order is watchdog two, watchdog one, pin; rest dropped
// RL19 - new pin request during pin service waits for the return
// RL20 - watchdog one during pin service waits while in-service flag set
// RL21 - watchdog one pre-empts pin service once in-service flag cleared
// RL22 - watchdog handlers end with a system reset, not a return
// RL23 - watchdog two pre-empts pin service whatever the flag holds
// RL24 - acceptance saves state, writes cause 0010H, sets flags, clears exception flag
// RL25 - pin edge selection is none after reset

module nva_arbiter #(
  parameter bit TWOWIRE_FITTED = 1'b1,
  parameter int MASK_COUNT = `NVA_MASK_COUNT
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // maskable sources, bit 0 is default priority 19
  input wire logic [MASK_COUNT-1:0] maskable_req,
  output logic [MASK_COUNT-1:0] maskable_taken_r,
  // non-maskable pin and its edge selection
  input wire logic nmi_pin,
  input wire logic edge_sel_wr,
  input wire logic [1:0] edge_sel_data,
  output logic [1:0] edge_sel_r,
  // watchdog overflows and their mode bits
  input wire logic wdog1_overflow_nmi,
  input wire logic wdog2_overflow_nmi,
  input wire logic wdog1_mode_bit_hi,
  input wire logic wdog1_mode_bit_lo,
  input wire logic wdog2_mode_bit_hi,
  input wire logic wdog2_mode_bit_lo,
  // core state and events
  input wire logic global_irq_disabled_state,
  input wire logic core_ack,
  input wire logic irq_return_instruction,
  input wire logic nmi_in_service_clear_wr,
  input wire logic abandon_instr,
  input wire logic [31:0] following_instruction_address,
  input wire logic [31:0] current_instruction_address,
  input wire logic [31:0] status_word,
  // vector offered to the core
  output logic irq_valid_r,
  output logic irq_nmi_r,
  output logic [15:0] irq_code_r,
  output logic [31:0] handler_addr_r,
  // saved state and status flags
  output logic [31:0] maskable_return_pc_save_r,
  output logic [31:0] nonmaskable_return_pc_save_r,
  output logic [31:0] nonmaskable_status_save_r,
  output logic [15:0] nonmaskable_cause_field_r,
  output logic nmi_in_service_flag_r,
  output logic interrupt_disable_flag_r,
  output logic exception_active_flag_r
);

  // ****************************************
  // elaboration check
  // ****************************************
  if (MASK_COUNT != `NVA_MASK_COUNT) begin : g_bad_count
    $error("maskable source count must match the code table");
  end

  // ****************************************
  // declarations
  // ****************************************
  nva_pkg::nva_state_e state_r;
  nva_pkg::nva_state_e state_nxt;
  nva_pkg::nva_kind_e kind_r;
  nva_pkg::nva_kind_e kind_nxt;
  logic pend_pin_r;
  logic pend_wd1_r;
  logic pend_wd2_r;
  logic [`NVA_IDX_W-1:0] idx_r;
  nva_pin_if pin_if ();

  // ****************************************
  // pin edge detection
  // ****************************************
  assign pin_if.edge_sel = edge_sel_r;

  nva_edge_sync u_edge (
    .clock(clock),
    .reset(reset),
    .pin_raw(nmi_pin),
    .link(pin_if.detect)
  );

  // edge selection register, none until software picks one
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      edge_sel_r <= `NVA_EDGE_NONE; // [RL25]
    end else if (edge_sel_wr) begin
      edge_sel_r <= edge_sel_data; // [RL15]
    end
  end

  // ****************************************
  // source qualification
  // ****************************************
  // two-wire sources vanish in variants without those buses
  function automatic logic [MASK_COUNT-1:0] fitted_mask();
    logic [MASK_COUNT-1:0] m;
    m = '1;
    if (!TWOWIRE_FITTED) begin
      m[`NVA_TWOWIRE0_IDX] = 1'b0; // [RL8]
      m[`NVA_TWOWIRE1_IDX] = 1'b0; // [RL8]
    end
    return m;
  endfunction

  // lowest index is the most urgent default priority
  function automatic logic [`NVA_IDX_W-1:0] lowest(input logic [MASK_COUNT-1:0] v);
    logic [`NVA_IDX_W-1:0] r;
    r = '0;
    for (int i = MASK_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = i[`NVA_IDX_W-1:0]; // [RL1] [RL2]
      end
    end
    return r;
  endfunction

  wire logic [MASK_COUNT-1:0] mask_live = maskable_req & fitted_mask();
  wire logic [`NVA_IDX_W-1:0] mask_idx = lowest(mask_live);
  // linear code table covers priorities 19 to 44
  wire logic [15:0] mask_code = `NVA_CODE_BASE +
    {7'h00, mask_idx, 4'h0}; // [RL3] [RL4] [RL5] [RL6] [RL7]

  // watchdog overflows only count in their own mode
  wire logic wd1_event = wdog1_overflow_nmi &&
    ({wdog1_mode_bit_hi, wdog1_mode_bit_lo} == `NVA_WD1_MODE); // [RL16]
  wire logic wd2_event = wdog2_overflow_nmi &&
    ({wdog2_mode_bit_hi, wdog2_mode_bit_lo} == `NVA_WD2_MODE); // [RL17]
  wire logic pin_event = pin_if.pin_edge;

  // ****************************************
  // selection
  // ****************************************
  wire logic in_idle = (state_r == nva_pkg::ST_IDLE);
  wire logic in_pin = (state_r == nva_pkg::ST_PIN);
  wire logic in_offer = (state_r == nva_pkg::ST_OFFER);
  wire logic nmi_any = pend_wd2_r || pend_wd1_r || pend_pin_r;
  // watchdog two always interrupts pin service
  wire logic can_wd2 = pend_wd2_r && (in_idle || in_pin); // [RL23]
  // watchdog one waits while the in-service flag is still set
  wire logic can_wd1 = pend_wd1_r &&
    (in_idle || (in_pin && !nmi_in_service_flag_r)); // [RL20] [RL21]
  // a pin request during pin service waits for the return
  wire logic can_pin = pend_pin_r && in_idle; // [RL19]
  // maskable only when nothing non-maskable waits
  wire logic can_mask = in_idle && |mask_live && !nmi_any &&
    !global_irq_disabled_state && !interrupt_disable_flag_r; // [RL13]
  wire logic accept = in_offer && core_ack;
  wire logic acc_nmi = accept && (kind_r != nva_pkg::KIND_MASK);
  wire logic acc_mask = accept && (kind_r == nva_pkg::KIND_MASK);
  wire logic pin_ret = in_pin && irq_return_instruction;
  // an offered request yields to a higher non-maskable one
  wire logic outranked =
    (kind_r == nva_pkg::KIND_MASK && nmi_any) ||
    (kind_r == nva_pkg::KIND_PIN && (pend_wd1_r || pend_wd2_r)) ||
    (kind_r == nva_pkg::KIND_WD1 && pend_wd2_r);
  wire logic [31:0] ret_addr = abandon_instr ?
    current_instruction_address : following_instruction_address; // [RL11]

  // next state and kind
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    case (state_r)
      nva_pkg::ST_IDLE, nva_pkg::ST_PIN: begin
        // fixed order among non-maskable requests
        if (can_wd2) begin
          state_nxt = nva_pkg::ST_OFFER;
          kind_nxt = nva_pkg::KIND_WD2; // [RL18]
        end else if (can_wd1) begin
          state_nxt = nva_pkg::ST_OFFER;
          kind_nxt = nva_pkg::KIND_WD1; // [RL18]
        end else if (can_pin) begin
          state_nxt = nva_pkg::ST_OFFER;
          kind_nxt = nva_pkg::KIND_PIN;
        end else if (can_mask) begin
          state_nxt = nva_pkg::ST_OFFER;
          kind_nxt = nva_pkg::KIND_MASK;
        end else if (pin_ret) begin
          state_nxt = nva_pkg::ST_IDLE; // [RL19]
        end
      end
      nva_pkg::ST_OFFER: begin
        if (core_ack) begin
          case (kind_r)
            nva_pkg::KIND_MASK: state_nxt = nva_pkg::ST_IDLE;
            nva_pkg::KIND_PIN: state_nxt = nva_pkg::ST_PIN;
            default: state_nxt = nva_pkg::ST_WDOG;
          endcase
        end else if (outranked) begin
          state_nxt = nva_pkg::ST_IDLE; // [RL13]
        end
      end
      // watchdog service ends only in a system reset
      nva_pkg::ST_WDOG: state_nxt = nva_pkg::ST_WDOG; // [RL22]
      default: state_nxt = nva_pkg::ST_IDLE;
    endcase
  end

  // ****************************************
  // pending requests
  // ****************************************
  // set wins over clear; watchdog service discards every later request
  wire logic take_ev = (state_r != nva_pkg::ST_WDOG);
  wire logic acc_wd = acc_nmi && (kind_r != nva_pkg::KIND_PIN);
  wire logic clr_wd2 = accept && kind_r == nva_pkg::KIND_WD2;
  wire logic clr_wd1 = clr_wd2 || (accept && kind_r == nva_pkg::KIND_WD1);
  wire logic clr_pin = acc_wd || (accept && kind_r == nva_pkg::KIND_PIN);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pend_pin_r <= 1'b0;
      pend_wd1_r <= 1'b0;
      pend_wd2_r <= 1'b0;
    end else begin
      pend_wd2_r <= (take_ev && wd2_event) || (pend_wd2_r && !clr_wd2); // [RL14]
      pend_wd1_r <= (take_ev && wd1_event) || (pend_wd1_r && !clr_wd1); // [RL14] [RL18]
      pend_pin_r <= (take_ev && pin_event) || (pend_pin_r && !clr_pin); // [RL14] [RL18]
    end
  end

  // ****************************************
  // state and offered vector
  // ****************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= nva_pkg::ST_IDLE;
      kind_r <= nva_pkg::KIND_MASK;
      idx_r <= '0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      idx_r <= (in_offer) ? idx_r : mask_idx;
    end
  end

  // vector outputs follow the next state so they line up with valid
  wire logic offer_nxt = (state_nxt == nva_pkg::ST_OFFER);
  wire logic nmi_nxt = (kind_nxt != nva_pkg::KIND_MASK);
  wire logic [15:0] code_nxt = nmi_nxt ? `NVA_NMI_CODE : mask_code;
  wire logic [31:0] hand_nxt = nmi_nxt ? `NVA_NMI_HANDLER :
    {16'h0000, mask_code}; // [RL9]

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_valid_r <= 1'b0;
      irq_nmi_r <= 1'b0;
      irq_code_r <= '0;
      handler_addr_r <= '0;
    end else begin
      irq_valid_r <= offer_nxt;
      if (!in_offer) begin
        irq_nmi_r <= nmi_nxt;
        irq_code_r <= code_nxt;
        handler_addr_r <= hand_nxt;
      end
    end
  end

  // one-cycle taken pulse lets the peripheral drop its request
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      maskable_taken_r <= '0;
    end else begin
      maskable_taken_r <= acc_mask ? (MASK_COUNT'(1) << idx_r) : '0;
    end
  end

  // ****************************************
  // saved state and flags
  // ****************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      maskable_return_pc_save_r <= '0;
      nonmaskable_return_pc_save_r <= '0;
      nonmaskable_status_save_r <= '0;
      nonmaskable_cause_field_r <= '0;
    end else if (acc_mask) begin
      maskable_return_pc_save_r <= ret_addr; // [RL10]
    end else if (acc_nmi) begin
      nonmaskable_return_pc_save_r <= ret_addr; // [RL10]
      nonmaskable_status_save_r <= status_word; // [RL24]
      nonmaskable_cause_field_r <= `NVA_NMI_CODE; // [RL24]
    end
  end

  // acceptance sets the disable flag, and a non-maskable one the in-service flag, over any clear in the same cycle;
  // only a non-maskable acceptance clears the exception flag
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      nmi_in_service_flag_r <= 1'b0;
      interrupt_disable_flag_r <= 1'b0;
      exception_active_flag_r <= 1'b0;
    end else begin
      nmi_in_service_flag_r <= acc_nmi ||
        (nmi_in_service_flag_r && !nmi_in_service_clear_wr && !pin_ret); // [RL24]
      interrupt_disable_flag_r <= accept ||
        (interrupt_disable_flag_r && !irq_return_instruction);
      exception_active_flag_r <= exception_active_flag_r && !acc_nmi; // [RL24]
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence s_nmi_taken;
    irq_valid_r && irq_nmi_r && core_ack;
  endsequence
  sequence s_nmi_saved;
    nonmaskable_cause_field_r == 16'h0010 && nmi_in_service_flag_r &&
    interrupt_disable_flag_r && !exception_active_flag_r;
  endsequence
  sequence s_wd2_offered;
    irq_valid_r && irq_nmi_r && kind_r == nva_pkg::KIND_WD2;
  endsequence

  AST_NMI_ENTRY: assert property (s_nmi_taken |=> s_nmi_saved) // [RL24]
    else $error("non-maskable entry did not set cause and flags");
  AST_HANDLER_ZX: assert property (irq_valid_r && !irq_nmi_r |->
    handler_addr_r == {16'h0000, irq_code_r}) // [RL9]
    else $error("handler address differs from code");
  AST_CODE_RANGE: assert property (irq_valid_r && !irq_nmi_r |->
    irq_code_r >= 16'h01B0 && irq_code_r <= 16'h0340 &&
    irq_code_r[3:0] == 4'h0) // [RL3]
    else $error("maskable code outside table");
  AST_LOWEST_WINS: assert property (can_mask |=>
    irq_valid_r && irq_code_r == $past(mask_code)) // [RL2]
    else $error("maskable pick not lowest default priority");
  AST_WD2_FIRST: assert property (in_idle && pend_wd2_r |=> s_wd2_offered) // [RL18]
    else $error("watchdog two not offered first");
  AST_WD2_PREEMPT: assert property (in_pin && pend_wd2_r |=> s_wd2_offered) // [RL23]
    else $error("watchdog two did not pre-empt pin service");
  AST_NMI_OVER_MASK: assert property (in_idle && nmi_any && |mask_live |=>
    irq_valid_r && irq_nmi_r) // [RL13]
    else $error("maskable request beat a non-maskable one");
  AST_WD1_HELD: assert property (in_pin && nmi_in_service_flag_r && // [RL20]
    !pend_wd2_r && !nmi_in_service_clear_wr && !irq_return_instruction |=>
    !irq_valid_r ##1 !(irq_valid_r && kind_r == nva_pkg::KIND_WD1))
    else $error("watchdog one taken while in service");
  AST_WD1_MODE: assert property (wdog1_overflow_nmi &&
    {wdog1_mode_bit_hi, wdog1_mode_bit_lo} != 2'h2 && !pend_wd1_r |=>
    !pend_wd1_r) // [RL16]
    else $error("watchdog one request in wrong mode");
  AST_WD2_MODE: assert property (wdog2_overflow_nmi &&
    {wdog2_mode_bit_hi, wdog2_mode_bit_lo} != 2'h1 && !pend_wd2_r |=>
    !pend_wd2_r) // [RL17]
    else $error("watchdog two request in wrong mode");
  AST_ABANDON_PC: assert property (accept && abandon_instr |=>
    $past(current_instruction_address) ==
    (irq_nmi_r ? nonmaskable_return_pc_save_r : maskable_return_pc_save_r)) // [RL11]
    else $error("abandoned instruction address not saved");
  AST_EDGE_NONE: assert property (edge_sel_r == 2'h0 && $past(edge_sel_r) == 2'h0 |->
    !pin_if.pin_edge) // [RL15]
    else $error("pin edge seen with selection none");

endmodule

// ===== rtl/nva_params.svh
`ifndef NVA_PARAMS_SVH
`define NVA_PARAMS_SVH

// ****************************************
// maskable window
// ****************************************
// index 0 of the request vector is default priority 19
`define NVA_MASK_FIRST_PRIO 19
`define NVA_MASK_COUNT 26
`define NVA_IDX_W 5
// exception code of index i is base plus i times sixteen
`define NVA_CODE_BASE 16'h01B0
`define NVA_CODE_STEP_SH 4
`define NVA_CODE_LAST 16'h0340
`define NVA_TWOWIRE0_IDX 6
`define NVA_TWOWIRE1_IDX 25

// ****************************************
// non-maskable path
// ****************************************
`define NVA_NMI_CODE 16'h0010
`define NVA_NMI_HANDLER 32'h0000_0010
`define NVA_WD1_MODE 2'h2
`define NVA_WD2_MODE 2'h1
`define NVA_EDGE_RISE_BIT 0
`define NVA_EDGE_FALL_BIT 1
`define NVA_EDGE_NONE 2'h0

`endif

// ===== rtl/nva_pkg.sv
package nva_pkg;
  // arbiter states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_OFFER = 4'h2,
    ST_PIN = 4'h4,
    ST_WDOG = 4'h8
  } nva_state_e;
  // kind of request being offered to the core, one-hot
  typedef enum logic [3:0] {
    KIND_MASK = 4'h1,
    KIND_PIN = 4'h2,
    KIND_WD1 = 4'h4,
    KIND_WD2 = 4'h8
  } nva_kind_e;
  typedef logic [15:0] nva_code_t;
endpackage

// ===== rtl/nva_pin_if.sv
interface nva_pin_if;
  logic [1:0] edge_sel;
  logic pin_edge;
  modport detect(input edge_sel, output pin_edge);
  modport user(output edge_sel, input pin_edge);
endinterface

// ===== rtl/nva_edge_sync.sv
`include "nva_params.svh"

module nva_edge_sync (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // raw pin level
  input wire logic pin_raw,
  // edge selection in, edge pulse out
  nva_pin_if.detect link
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic edge_r;

  // a change counts only once stages two and three agree
  wire logic settled = (s2_r == s3_r);
  wire logic moved = settled && (s3_r != level_r);
  wire logic rise_hit = moved && s3_r && link.edge_sel[`NVA_EDGE_RISE_BIT];
  wire logic fall_hit = moved && !s3_r && link.edge_sel[`NVA_EDGE_FALL_BIT];

  // three-stage synchroniser and settled level
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
      edge_r <= 1'b0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= settled ? s3_r : level_r;
      edge_r <= rise_hit || fall_hit; // [RL15]
    end
  end

  assign link.pin_edge = edge_r;

endmodule

// ===== test/nva_core_model.sv
module nva_core_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // offer from the arbiter
  input wire logic irq_valid,
  // answer pacing, 0 is prompt
  input wire logic [3:0] ack_delay,
  // take of the offered vector
  output logic core_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_r;
  // ****************************************
  // acceptance pacing
  // ****************************************
  // a withdrawn offer restarts the count, so a slow core never takes a stale vector
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wait_r <= 4'h0;
      core_ack <= 1'h0;
    end else begin
      core_ack <= irq_valid && !core_ack && wait_r == ack_delay;
      wait_r <= (irq_valid && !core_ack) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

// ===== test/nva_arbiter_tb_top.sv
module nva_arbiter_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  localparam logic [31:0] NEXT_PC = 32'h0000_1000;
  localparam logic [31:0] THIS_PC = 32'h0000_0FFC;
  localparam logic [31:0] STATUS = 32'h0000_00A5;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic [25:0] maskable_req = 26'h0;
  logic [4:0] pulse_r = 5'h0;
  logic [3:0] wd_modes = 4'h9;
  logic [3:0] ack_delay = 4'h0;
  logic [1:0] edge_sel_data = 2'h0;
  logic nmi_pin = 1'h0;
  logic global_irq_disabled_state = 1'h0;
  logic abandon_instr = 1'h0;
  logic [31:0] following_instruction_address = NEXT_PC;
  logic [31:0] current_instruction_address = THIS_PC;
  logic [31:0] status_word = STATUS;
  logic core_ack, irq_valid_r, irq_nmi_r, nmi_in_service_flag_r, interrupt_disable_flag_r, exception_active_flag_r;
  logic [25:0] maskable_taken_r;
  logic [1:0] edge_sel_r;
  logic [15:0] irq_code_r, nonmaskable_cause_field_r;
  logic [31:0] handler_addr_r, maskable_return_pc_save_r, nonmaskable_return_pc_save_r, nonmaskable_status_save_r;
  int failures = 0;
  int comparisons = 0;
  // expected vector of each maskable source, lowest index most urgent
  logic [15:0] codes [26] = '{16'h01B0, 16'h01C0, 16'h01D0, 16'h01E0, 16'h01F0, 16'h0200, 16'h0210, 16'h0220,
    16'h0230, 16'h0240, 16'h0250, 16'h0260, 16'h0270, 16'h0280, 16'h0290, 16'h02A0, 16'h02B0, 16'h02C0, 16'h02D0,
    16'h02E0, 16'h02F0, 16'h0300, 16'h0310, 16'h0320, 16'h0330, 16'h0340};

  always #2 clock = ~clock;

  // ****************************************
  // design and partner
  // ****************************************
  nva_arbiter #(.TWOWIRE_FITTED(1'h1)) uut (.clock, .reset, .maskable_req, .maskable_taken_r, .nmi_pin,
    .edge_sel_wr(pulse_r[4]), .edge_sel_data, .edge_sel_r, .wdog1_overflow_nmi(pulse_r[0]),
    .wdog2_overflow_nmi(pulse_r[1]), .wdog1_mode_bit_hi(wd_modes[3]), .wdog1_mode_bit_lo(wd_modes[2]),
    .wdog2_mode_bit_hi(wd_modes[1]), .wdog2_mode_bit_lo(wd_modes[0]), .global_irq_disabled_state, .core_ack,
    .irq_return_instruction(pulse_r[2]), .nmi_in_service_clear_wr(pulse_r[3]), .abandon_instr,
    .following_instruction_address,
    .current_instruction_address, .status_word, .irq_valid_r, .irq_nmi_r, .irq_code_r, .handler_addr_r,
    .maskable_return_pc_save_r, .nonmaskable_return_pc_save_r, .nonmaskable_status_save_r,
    .nonmaskable_cause_field_r, .nmi_in_service_flag_r, .interrupt_disable_flag_r, .exception_active_flag_r);
  nva_core_model core (.clock, .reset, .irq_valid(irq_valid_r), .ack_delay, .core_ack);

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic complete_run();
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // inputs always change a little after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_quiet(input int n);
    repeat (n) begin
      step(1);
      check_val(irq_valid_r, 1'h0);
    end
  endtask

  // sel 0 offer up, 1 offer gone, 2 taken pulse; bounded so a hang ends the run
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while (!(sel == 0 ? irq_valid_r === 1'h1 : sel == 1 ? irq_valid_r === 1'h0 : |maskable_taken_r === 1'h1)) begin
      n++;
      if (n > 40) begin
        check_val(64'h0, 64'h1);
        complete_run();
      end
      step(1);
    end
  endtask

  // one-cycle strobes: wd1, wd2, return, in-service clear, edge write
  task automatic pulse(input logic [4:0] p);
    pulse_r = p;
    step(1);
    pulse_r = 5'h0;
  endtask

  task automatic do_reset(input int n);
    reset = 1'h1;
    step(n);
    reset = 1'h0;
    check_val({edge_sel_r, irq_valid_r, nmi_in_service_flag_r, interrupt_disable_flag_r}, 64'h0);
  endtask

  task automatic take_nmi();
    wait_for(0);
    check_val({irq_nmi_r, irq_code_r, handler_addr_r}, {1'h1, 16'h0010, 32'h0000_0010});
    wait_for(1);
  endtask

  task automatic enter_pin(input logic [1:0] sel, input logic level);
    edge_sel_data = sel;
    pulse(5'h10);
    check_val(edge_sel_r, sel);
    nmi_pin = level;
    take_nmi();
    check_val({nonmaskable_cause_field_r, nmi_in_service_flag_r, interrupt_disable_flag_r, exception_active_flag_r},
      {16'h0010, 3'h6});
    check_val({nonmaskable_return_pc_save_r, nonmaskable_status_save_r}, {NEXT_PC, STATUS});
    check_val(nonmaskable_return_pc_save_r - 32'h4, THIS_PC);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    do_reset(20);
    maskable_req = 26'h3FFFFFF;
    // all sources at once must drain in default order
    for (int i = 0; i < 26; i++) begin
      abandon_instr = (i == 5);
      wait_for(0);
      check_val({irq_nmi_r, irq_code_r, handler_addr_r}, {1'h0, codes[i], 16'h0, codes[i]});
      wait_for(2);
      check_val(maskable_taken_r, 26'h1 << i);
      check_val({maskable_return_pc_save_r, interrupt_disable_flag_r}, {(i == 5) ? THIS_PC : NEXT_PC, 1'h1});
      maskable_req[i] = 1'h0;
      pulse(5'h04);
    end
    abandon_instr = 1'h0;
    ack_delay = 4'h3;
    // pin with no edge selected, maskable blocked by the disable state
    global_irq_disabled_state = 1'h1;
    maskable_req = 26'h1;
    nmi_pin = 1'h1;
    check_quiet(10);
    nmi_pin = 1'h0;
    step(6);
    enter_pin(2'h1, 1'h1);
    nmi_pin = 1'h0;
    step(6);
    nmi_pin = 1'h1;
    check_quiet(10);
    pulse(5'h04);
    take_nmi();
    pulse(5'h01);
    check_quiet(8);
    pulse(5'h04);
    take_nmi();
    do_reset(3);
    // first watchdog: wrong mode ignored, then pre-emption after the flag is cleared
    global_irq_disabled_state = 1'h0;
    maskable_req = 26'h0;
    ack_delay = 4'h0;
    wd_modes = 4'hD;
    pulse(5'h01);
    check_quiet(8);
    wd_modes = 4'h9;
    enter_pin(2'h2, 1'h0);
    pulse(5'h08);
    check_val(nmi_in_service_flag_r, 1'h0);
    step(1);
    pulse(5'h01);
    take_nmi();
    do_reset(3);
    // second watchdog: wrong mode ignored, then pre-emption with the flag still set
    wd_modes = 4'hA;
    pulse(5'h02);
    check_quiet(8);
    wd_modes = 4'h9;
    enter_pin(2'h3, 1'h1);
    pulse(5'h02);
    take_nmi();
    do_reset(3);
    // coincident watchdogs: one served, the other dropped, maskable refused
    pulse(5'h03);
    maskable_req = 26'h1;
    take_nmi();
    pulse(5'h04);
    check_quiet(20);
    complete_run();
  end
endmodule
